// File: inc/sseq_defs.vh
// Purpose: Constants for the supply sequencing state engine
// Assumes: 250 MHz mclk, AXI4-Lite register access
// Notes:   Shared by the engine and its bench
`ifndef SSEQ_DEFS_VH
`define SSEQ_DEFS_VH
// Timing, last definition word index and last state index
`define SSEQ_CLK_NS      4
`define SSEQ_TICK_NS     10000
`define SSEQ_TICK_LAST   12'h9C3   // Last count of 2500 mclk cycles per 10 us tick
`define SSEQ_CLKO_HALF_NS 5000
`define SSEQ_CLKO_LAST   12'h4E1   // Last count of 1250 cycles per 100 kHz half period
`define SSEQ_LOAD_US     20
`define SSEQ_DEF_WORDS   2'h3
`define SSEQ_LAST_STATE  6'h3E
// Register byte offsets
`define SSEQ_A_CTRL      8'h00
`define SSEQ_A_STATUS    8'h04
`define SSEQ_A_JUMP      8'h08
`define SSEQ_A_PADDR     8'h0C
`define SSEQ_A_PDATA     8'h10
`define SSEQ_A_OSRC      8'h14
`define SSEQ_A_OBUS      8'h18
`define SSEQ_A_DINCFG    8'h1C
`define SSEQ_A_ISTAT     8'h20
`define SSEQ_A_IMASK     8'h24
// Definition word 0 fields
`define SSEQ_W0_LVL      9:0
`define SSEQ_W0_STGT     15:10
`define SSEQ_W0_SSEL     19:16
`define SSEQ_W0_SPOL     20
`define SSEQ_W0_SEN      21
`define SSEQ_W0_TTGT     27:22
// Word 1: sequence delay; word 2: timeout; word 3: monitor
`define SSEQ_W1_SDLY     15:0
`define SSEQ_W2_TDLY     15:0
`define SSEQ_W2_TSEL     19:16
`define SSEQ_W2_TPOL     20
`define SSEQ_W2_TEN      21
`define SSEQ_W3_MASK     10:0
`define SSEQ_W3_SFD      9:0
`define SSEQ_W3_WRN      10
`define SSEQ_W3_MTGT     17:12
// Interrupt bits
`define SSEQ_I_CHG       0
`define SSEQ_I_MON       1
`define SSEQ_I_TMO       2
`define SSEQ_I_WARN      3
// Output source codes and bus response codes
`define SSEQ_SRC_ENG     2'h0
`define SSEQ_SRC_BUS     2'h1
`define SSEQ_SRC_CLK     2'h2
`define SSEQ_RESP_OK     2'h0
`define SSEQ_RESP_DEC    2'h3
`endif

// File: hw/sseq_engine.v
// Purpose: Supply sequencing state engine with AXI4-Lite register access
// Assumes: Supply detector, warning and digital pins are asynchronous to mclk
// Notes:   State definitions live in an indirect program memory of four words per state
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`include "sseq_defs.vh"
`default_nettype none
module sseq_engine (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst,
  // AXI4-Lite write address and data
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Supervised inputs: sfd_ok_in high means in tolerance, warn_in high means warning
  input  wire [9:0]  sfd_ok_in,
  input  wire [9:0]  warn_in,
  input  wire [4:0]  dual_function_input,
  // Drivers and interrupt
  output reg  [9:0]  prog_drv_out,
  output reg         irq
);

  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  // Program memory, four words per state
  reg  [31:0] prog_mem [0:255];
  reg  [31:0] w0_r, w1_r, w2_r, w3_r;
  reg  [2:0]  st_r;
  reg  [5:0]  cur_r;
  reg  [1:0]  ld_idx_r;
  reg  [15:0] seq_cnt_r, tmo_cnt_r;
  reg  [11:0] tick_cnt_r;
  reg         tick_r;
  reg  [11:0] clk_div_r;
  reg         clk100_r;
  reg         run_r;
  reg  [5:0]  jump_tgt_r;
  reg         jump_pend_r;
  reg  [7:0]  paddr_r;
  reg  [19:0] osrc_r;
  reg  [9:0]  obus_r;
  reg  [9:0]  eng_lvl_r;
  reg  [4:0]  din_edge_r;
  reg  [3:0]  din_width_r;
  reg  [3:0]  istat_r, imask_r;
  reg  [9:0]  sfd_s1_r, sfd_s2_r, warn_s1_r, warn_s2_r;
  reg  [4:0]  din_s1_r, din_s2_r, din_d_r;
  reg  [4:0]  din_cond;
  reg  [7:0]  aw_addr_r, ar_addr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         aw_hold_r, w_hold_r;

  wire        warn_any = |warn_s2_r;
  wire [15:0] eng_in   = {warn_any, din_cond, sfd_s2_r};
  wire [31:0] wmask    = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] pword    = prog_mem[paddr_r];
  wire [31:0] pword_nxt = (pword & ~wmask) | (wdata_r & wmask);
  wire        do_wr    = aw_hold_r & w_hold_r & ~s_axi_bvalid;

  // Sync pins: first stage feeds only the second
  always @(posedge mclk) begin
    sfd_s1_r  <= sfd_ok_in;
    sfd_s2_r  <= sfd_s1_r;
    warn_s1_r <= warn_in;
    warn_s2_r <= warn_s1_r;
    din_s1_r  <= dual_function_input;
    din_s2_r  <= din_s1_r;
    din_d_r   <= din_s2_r;
  end

  // 10 us tick and 100 kHz clock dividers, free running
  always @(posedge mclk) begin
    if (rst) begin
      tick_cnt_r <= 12'h000;
      tick_r     <= 1'b0;
      clk_div_r  <= 12'h000;
      clk100_r   <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == `SSEQ_TICK_LAST);
      tick_cnt_r <= (tick_cnt_r == `SSEQ_TICK_LAST) ? 12'h000 : tick_cnt_r + 12'h001;
      if (clk_div_r == `SSEQ_CLKO_LAST) begin
        clk_div_r <= 12'h000;
        clk100_r  <= ~clk100_r;
      end else begin
        clk_div_r <= clk_div_r + 12'h001;
      end
    end
  end

  // Digital input conditioning, one stage per pin
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_din
      reg [3:0] pw_cnt_r;
      reg       pulse_r;
      always @(posedge mclk) begin
        if (rst) begin
          pw_cnt_r <= 4'h0;
          pulse_r  <= 1'b0;
        end else if (din_s2_r[gi] & ~din_d_r[gi]) begin
          pw_cnt_r <= din_width_r;
          pulse_r  <= (din_width_r != 4'h0);
        end else if (tick_r & pulse_r) begin
          pw_cnt_r <= pw_cnt_r - 4'h1;
          pulse_r  <= (pw_cnt_r != 4'h1);
        end
      end
      // Edge mode gives a timed pulse, level mode a buffered copy
      always @* begin
        din_cond[gi] = din_edge_r[gi] ? pulse_r : din_s2_r[gi];
      end
    end
  endgenerate

  // Exit evaluation for the current definition
  wire        seq_cond = (eng_in[w0_r[`SSEQ_W0_SSEL]] == w0_r[`SSEQ_W0_SPOL]);
  wire        seq_hit  = w0_r[`SSEQ_W0_SEN] & seq_cond & (seq_cnt_r >= w1_r[`SSEQ_W1_SDLY]);
  wire        tmo_hit  = w2_r[`SSEQ_W2_TEN] & (tmo_cnt_r >= w2_r[`SSEQ_W2_TDLY]) &
                         (eng_in[w2_r[`SSEQ_W2_TSEL]] != w2_r[`SSEQ_W2_TPOL]);
  wire        mon_hit  = |(w3_r[`SSEQ_W3_SFD] & ~sfd_s2_r) | (w3_r[`SSEQ_W3_WRN] & warn_any);
  reg         exit_go;
  reg  [5:0]  exit_tgt;
  always @* begin
    exit_go  = 1'b1;
    exit_tgt = 6'h00;
    if (mon_hit)          exit_tgt = w3_r[`SSEQ_W3_MTGT];
    else if (tmo_hit)     exit_tgt = w0_r[`SSEQ_W0_TTGT];
    else if (jump_pend_r) exit_tgt = jump_tgt_r;
    else if (seq_hit)     exit_tgt = w0_r[`SSEQ_W0_STGT];
    else                  exit_go  = 1'b0;
    // Unprogrammable index 63 is never entered
    if (exit_tgt > `SSEQ_LAST_STATE) exit_go = 1'b0;
  end

  // Engine state machine; a state may re-enter itself to rearm timers, which makes a
  // clock watchdog: edge pulse re-enters, timeout with no pulse goes to the fault state
  always @(posedge mclk) begin
    if (rst) begin
      st_r      <= ST_HOLD;
      cur_r     <= 6'h00;
      ld_idx_r  <= 2'h0;
      w0_r      <= 32'h0000_0000;
      w1_r      <= 32'h0000_0000;
      w2_r      <= 32'h0000_0000;
      w3_r      <= 32'h0000_0000;
      eng_lvl_r <= 10'h000;
      seq_cnt_r <= 16'h0000;
      tmo_cnt_r <= 16'h0000;
    end else begin
      case (st_r)
        ST_HOLD: begin
          cur_r     <= 6'h00;
          seq_cnt_r <= 16'h0000;
          tmo_cnt_r <= 16'h0000;
          ld_idx_r  <= 2'h0;
          if (run_r) st_r <= ST_LOAD;
        end
        ST_LOAD: begin
          // Four-cycle definition fetch, far inside the 20 us budget
          case (ld_idx_r)
            2'h0: begin
              w0_r      <= prog_mem[{cur_r, 2'h0}];
              eng_lvl_r <= prog_mem[{cur_r, 2'h0}][`SSEQ_W0_LVL];
            end
            2'h1: w1_r <= prog_mem[{cur_r, 2'h1}];
            2'h2: w2_r <= prog_mem[{cur_r, 2'h2}];
            default: w3_r <= prog_mem[{cur_r, 2'h3}];
          endcase
          seq_cnt_r <= 16'h0000;
          tmo_cnt_r <= 16'h0000;
          ld_idx_r  <= ld_idx_r + 2'h1;
          if (ld_idx_r == `SSEQ_DEF_WORDS) st_r <= ST_RUN;
        end
        ST_RUN: begin
          if (!run_r) begin
            st_r <= ST_HOLD;
          end else if (exit_go) begin
            cur_r    <= exit_tgt;
            ld_idx_r <= 2'h0;
            st_r     <= ST_LOAD;
          end else begin
            // Sequence delay counts in 10 us ticks and restarts when input drops
            if (!seq_cond) seq_cnt_r <= 16'h0000;
            else if (tick_r && seq_cnt_r < w1_r[`SSEQ_W1_SDLY])
              seq_cnt_r <= seq_cnt_r + 16'h0001;
            if (tick_r && tmo_cnt_r < w2_r[`SSEQ_W2_TDLY])
              tmo_cnt_r <= tmo_cnt_r + 16'h0001;
          end
        end
        default: st_r <= ST_HOLD;
      endcase
    end
  end

  // Driver source selection, registered straight to pins
  genvar go;
  generate
    for (go = 0; go < 10; go = go + 1) begin : g_drv
      always @(posedge mclk) begin
        if (rst) prog_drv_out[go] <= 1'b0;
        else case (osrc_r[2*go+1:2*go])
          `SSEQ_SRC_ENG: prog_drv_out[go] <= eng_lvl_r[go];
          `SSEQ_SRC_BUS: prog_drv_out[go] <= obus_r[go];
          `SSEQ_SRC_CLK: prog_drv_out[go] <= clk100_r;
          default:       prog_drv_out[go] <= 1'b0;
        endcase
      end
    end
  endgenerate

  // Program memory writes; has no reset so it maps to RAM
  always @(posedge mclk) begin
    if (do_wr && aw_addr_r == `SSEQ_A_PDATA && paddr_r[7:2] <= `SSEQ_LAST_STATE)
      prog_mem[paddr_r] <= pword_nxt;
  end

  // Write channel: address and data taken in either order
  wire aw_ok = (aw_addr_r <= `SSEQ_A_IMASK) && (aw_addr_r[1:0] == 2'h0);
  wire [3:0] ev = {warn_any, 1'b0, 1'b0, 1'b0};
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSEQ_RESP_OK;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      run_r         <= 1'b0;
      jump_tgt_r    <= 6'h00;
      jump_pend_r   <= 1'b0;
      paddr_r       <= 8'h00;
      osrc_r        <= 20'h00000;
      obus_r        <= 10'h000;
      din_edge_r    <= 5'h00;
      din_width_r   <= 4'h0;
      istat_r       <= 4'h0;
      imask_r       <= 4'h0;
      irq           <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_hold_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_hold_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      // Jump consumed on the exit it causes; a new command wins
      if (st_r == ST_RUN && exit_go && !mon_hit && !tmo_hit) jump_pend_r <= 1'b0;
      if (st_r != ST_RUN) jump_pend_r <= 1'b0;
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_ok ? `SSEQ_RESP_OK : `SSEQ_RESP_DEC;
        case (aw_addr_r)
          `SSEQ_A_CTRL:   if (wstrb_r[0]) run_r <= wdata_r[0];
          `SSEQ_A_JUMP:   if (wstrb_r[0]) begin
            jump_tgt_r  <= wdata_r[5:0];
            jump_pend_r <= 1'b1;
          end
          `SSEQ_A_PADDR:  if (wstrb_r[0]) paddr_r <= wdata_r[7:0];
          `SSEQ_A_OSRC:   osrc_r <= (osrc_r & ~wmask[19:0]) | (wdata_r[19:0] & wmask[19:0]);
          `SSEQ_A_OBUS:   obus_r <= (obus_r & ~wmask[9:0]) | (wdata_r[9:0] & wmask[9:0]);
          `SSEQ_A_DINCFG: begin
            if (wstrb_r[0]) din_edge_r  <= wdata_r[4:0];
            if (wstrb_r[1]) din_width_r <= wdata_r[11:8];
          end
          `SSEQ_A_IMASK:  if (wstrb_r[0]) imask_r <= wdata_r[3:0];
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
      end
      // Sticky status: hardware set beats a same-cycle write-one clear
      begin : b_istat
        reg [3:0] set_v, clr_v, nxt_v;
        set_v = ev;
        set_v[`SSEQ_I_CHG] = (st_r == ST_RUN) & exit_go;
        set_v[`SSEQ_I_MON] = (st_r == ST_RUN) & exit_go & mon_hit;
        set_v[`SSEQ_I_TMO] = (st_r == ST_RUN) & exit_go & ~mon_hit & tmo_hit;
        clr_v = (do_wr && aw_addr_r == `SSEQ_A_ISTAT && wstrb_r[0]) ? wdata_r[3:0] : 4'h0;
        nxt_v = (istat_r & ~clr_v) | set_v;
        istat_r <= nxt_v;
        irq     <= |(nxt_v & imask_r);
      end
    end
  end

  // Read channel, answer one cycle after address is taken
  reg [31:0] rd_mux;
  always @* begin
    case (s_axi_araddr[7:0])
      `SSEQ_A_CTRL:   rd_mux = {31'h0, run_r};
      `SSEQ_A_STATUS: rd_mux = {6'h00, sfd_s2_r, 5'h00, eng_lvl_r[3:0], st_r == ST_LOAD, cur_r};
      `SSEQ_A_JUMP:   rd_mux = {25'h0, jump_pend_r, jump_tgt_r};
      `SSEQ_A_PADDR:  rd_mux = {24'h0, paddr_r};
      `SSEQ_A_PDATA:  rd_mux = prog_mem[paddr_r];
      `SSEQ_A_OSRC:   rd_mux = {12'h000, osrc_r};
      `SSEQ_A_OBUS:   rd_mux = {22'h0, obus_r};
      `SSEQ_A_DINCFG: rd_mux = {20'h0, din_width_r, 3'h0, din_edge_r};
      `SSEQ_A_ISTAT:  rd_mux = {28'h0, istat_r};
      `SSEQ_A_IMASK:  rd_mux = {28'h0, imask_r};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SSEQ_RESP_OK;
      ar_addr_r     <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        ar_addr_r     <= s_axi_araddr[7:0];
        s_axi_rresp   <= (s_axi_araddr[7:0] <= `SSEQ_A_IMASK && s_axi_araddr[1:0] == 2'h0) ?
                         `SSEQ_RESP_OK : `SSEQ_RESP_DEC;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // sseq_engine
`default_nettype wire

// File: test/sseq_supply_model.sv
// Purpose: Supply rails that come good a fixed time after their enable
// Assumes: Enables are the engine driver levels
// Notes:   fail_in pulls a rail out of tolerance on demand
`default_nettype none
module sseq_supply_model #(
  parameter int RAMP = 16
) (
  // Clock
  input  wire logic       mclk,
  // Enables and injected faults
  input  wire logic [9:0] enable_in,
  input  wire logic [9:0] fail_in,
  // Rail status, high means in tolerance
  output var  logic [9:0] ok_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] hist_r [RAMP];
  // Ramp delay, so the engine never sees power good at once
  always @(posedge mclk) begin
    hist_r[0] <= enable_in;
    for (int i = 1; i < RAMP; i++)
      hist_r[i] <= hist_r[i-1];
  end
  // A disabled rail drops at once, a faulted rail reads bad
  assign ok_out = hist_r[RAMP-1] & enable_in & ~fail_in;
endmodule // sseq_supply_model
`default_nettype wire

// File: test/sseq_engine_sva.sv
// Purpose: Bus and reset checks on the sequencing engine ports
// Assumes: Master keeps the AXI4-Lite channel rules
// Notes:   Attached by the bind at the foot
`default_nettype none
module sseq_engine_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Bus handshakes and answers
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Engine outputs
  input wire logic [9:0]  prog_drv_out,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Answers stand until taken
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read answer dropped early");
  a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not cleared");
  // Answer timing fixed: read one cycle after the handshake, write two cycles
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while answering");
  a_resp_legal: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h3)
    else $error("odd read response code");
  // Own disable, reset itself is the cause here
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid
    && prog_drv_out == 10'h000 && !irq) else $error("outputs live after reset");
  c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
endmodule // sseq_engine_sva
bind sseq_engine sseq_engine_sva sseq_engine_sva_inst (.mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .prog_drv_out(prog_drv_out), .irq(irq));
`default_nettype wire

// File: test/sseq_engine_tb.sv
// Purpose: Walks the engine through a sample program over the bus
// Assumes: Supply model closes the loop from drivers to detectors
// Notes:   Each state has distinct driver levels, used to spot arrival
`include "sseq_defs.vh"
`default_nettype none
module sseq_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_q, r;
  logic [3:0]  s_axi_wstrb;
  logic [9:0]  sfd_ok, warn, drv, fail;
  int          fails = 0, checks = 0, cyc = 0, n;
  logic        b;
  logic [4:0]  din;
  sseq_engine sseq_engine_inst (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sfd_ok_in(sfd_ok), .warn_in(warn), .dual_function_input(din), .prog_drv_out(drv), .irq);
  sseq_supply_model sseq_supply_model_inst (.mclk, .enable_in(drv), .fail_in(fail), .ok_out(sfd_ok));
  // Clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write, releasing each channel once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit aw_done = 1'b0;
    bit w_done = 1'b0;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    bresp_q = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic chk_state(input logic [5:0] s);
    rd(`SSEQ_A_STATUS, d, r);
    chk("state", {26'h0000000, d[5:0]}, {26'h0000000, s});
  endtask
  // Arrival is seen as the new state's driver levels
  task automatic wdrv(input logic [9:0] exp, input int lim);
    n = 0;
    while (drv !== exp && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk("drivers", 32'(drv), 32'(exp));
  endtask
  // Four definition words through the indirect window
  task automatic pg(input logic [5:0] s, input logic [31:0] w0, w1, w2, w3);
    logic [31:0] w [4];
    w = '{w0, w1, w2, w3};
    for (int k = 0; k < 4; k++) begin
      wr(`SSEQ_A_PADDR, {24'h000000, s, k[1:0]});
      wr(`SSEQ_A_PDATA, w[k]);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {mclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    rst = 1'b1;
    s_axi_wstrb = 4'hF;
    warn = 10'h000;
    din = 5'h00;
    fail = 10'h004;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("drivers", 32'(drv), 32'h00000000);
    chk_state(6'h00);
    // Seq to 5; 5: seq on rail 1 after 4 ticks, monitor rail 0; 7: timeout on rail 2
    pg(6'h00, 32'h00301401, 32'h00000000, 32'h00000000, 32'h00000000);
    pg(6'h05, 32'h00311C03, 32'h00000004, 32'h00000000, 32'h00009001);
    pg(6'h07, 32'h03000007, 32'h00000000, 32'h00320001, 32'h00000000);
    pg(6'h0C, 32'h00000200, 32'h00000000, 32'h00000000, 32'h00014400);
    pg(6'h14, 32'h00000155, 32'h00000000, 32'h00000000, 32'h00000000);
    pg(6'h21, 32'h0A64AAAA, 32'h00000000, 32'h00300000, 32'h00028001);
    pg(6'h28, 32'h000000F0, 32'h00000000, 32'h00000000, 32'h00000000);
    wr(`SSEQ_A_IMASK, 32'h00000008);
    wr(`SSEQ_A_CTRL, 32'h00000001);
    wdrv(10'h001, 100);
    wdrv(10'h003, 4999);
    chk_state(6'h05);
    // Glitch mid-delay must restart the hold count
    repeat (5000) @(posedge mclk);
    fail[1] <= 1'b1;
    repeat (20) @(posedge mclk);
    fail[1] <= 1'b0;
    repeat (5980) @(posedge mclk);
    chk("drivers", 32'(drv), 32'h00000003);
    wdrv(10'h007, 5000);
    wdrv(10'h200, 5100);
    fail <= 10'h000;
    chk("irq", 32'(irq), 32'h00000000);
    warn[5] <= 1'b1;
    wdrv(10'h155, 100);
    repeat (3) @(posedge mclk);
    chk("irq", 32'(irq), 32'h00000001);
    wr(`SSEQ_A_IMASK, 32'h00000000);
    repeat (3) @(posedge mclk);
    chk("irq", 32'(irq), 32'h00000000);
    wr(`SSEQ_A_IMASK, 32'h00000008);
    repeat (3) @(posedge mclk);
    chk("irq", 32'(irq), 32'h00000001);
    warn[5] <= 1'b0;
    repeat (6) @(posedge mclk);
    wr(`SSEQ_A_ISTAT, 32'h0000000F);
    repeat (3) @(posedge mclk);
    chk("irq", 32'(irq), 32'h00000000);
    rd(`SSEQ_A_ISTAT, d, r);
    chk("istat", d, 32'h00000000);
    // Rail 0 bad: monitor, timeout and sequence all true on entry to 33
    fail <= 10'h001;
    repeat (6) @(posedge mclk);
    wr(`SSEQ_A_JUMP, 32'h00000021);
    wdrv(10'h0F0, 200);
    chk_state(6'h28);
    // Driver 9 from bus, 8 from clock, 5 forced low
    wr(`SSEQ_A_OSRC, 32'h00060C00);
    wr(`SSEQ_A_OBUS, 32'h00000200);
    repeat (3) @(posedge mclk);
    chk("drivers", 32'(drv & 10'h2FF), 32'h000002D0);
    b = drv[8];
    n = 0;
    while (drv[8] === b && n < 1300) begin
      @(posedge mclk);
      n++;
    end
    chk("clock toggle", 32'(n < 1300), 32'h00000001);
    rd(8'h30, d, r);
    chk("unmapped rdata", d, 32'h00000000);
    chk("unmapped rresp", 32'(r), 32'h00000003);
    wr(8'h3C, 32'h00000000);
    chk("unmapped bresp", 32'(bresp_q), 32'h00000003);
    // Edge mode: a pin already high is no event, a fresh rising edge exits 48 to 49
    pg(6'h30, 32'h003AC4AA, 32'h00000000, 32'h00000000, 32'h00000000);
    pg(6'h31, 32'h00000111, 32'h00000000, 32'h00000000, 32'h00000000);
    wr(`SSEQ_A_OSRC, 32'h00000000);
    wr(`SSEQ_A_DINCFG, 32'h00000101);
    din <= 5'h01;
    repeat (5100) @(posedge mclk);
    wr(`SSEQ_A_JUMP, 32'h00000030);
    wdrv(10'h0AA, 200);
    repeat (100) @(posedge mclk);
    chk("drivers", 32'(drv), 32'h000000AA);
    din <= 5'h00;
    repeat (4) @(posedge mclk);
    din <= 5'h01;
    wdrv(10'h111, 200);
    end_of_test();
  end
endmodule // sseq_engine_tb
`default_nettype wire
